// [include/pm_clock_params.svh]
/*
  Offsets, field positions, reset values and timing counts of the power-mode
  and clock manager. Assumes an 8-bit register port with a 2-bit address.
*/
`ifndef PM_CLOCK_PARAMS_SVH
`define PM_CLOCK_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define PM_ADDR_POWER_CONTROL_REG 2'h0
`define PM_ADDR_PMR 2'h1
`define PM_ADDR_EXT_INT_FLAG_REG 2'h2
`define PM_ADDR_STATUS 2'h3

// ****************************************
// field positions
// ****************************************
`define PM_POWER_CONTROL_REG_IDLE 0
`define PM_POWER_CONTROL_REG_PDOWN 1
`define PM_PMR_AMPOFF 3
`define PM_PMR_SWB 5
`define PM_PMR_DIV_LO 6
`define PM_EXT_INT_FLAG_REG_RCWAKE 1
`define PM_EXT_INT_FLAG_REG_RCACT 2
`define PM_EXT_INT_FLAG_REG_SRCSEL 3
`define PM_STATUS_XTRDY 4

// ****************************************
// reset values and divide codes
// ****************************************
`define PM_PMR_RESET 8'h40
`define PM_EXT_INT_FLAG_REG_RESET 8'h00
`define PM_DIV_RSV 2'h0
`define PM_DIV_4 2'h1
`define PM_DIV_64 2'h2
`define PM_DIV_1024 2'h3

// ****************************************
// timing counts, in ref_clk periods
// ****************************************
`define PM_RST_MIN_CLKS 8
`define PM_WDT_RST_CLKS 512

`endif

// [include/pm_clock_pkg.sv]
/*
  Types of the power-mode and clock manager.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package pm_clock_pkg;
  // operating mode of the core
  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PDOWN} pm_state_t;
endpackage

`default_nettype wire

// [core/power_mode_clock_manager.sv]
/*
  Power-mode and clock-rate manager: idle, economy divide, power-down,
  crystal / RC source selection and wake-up. Assumes a free-running ref_clk,
  a CPU that pulses instr_done at the end of each instruction and that owns
  interrupt priority, and same-domain strobes from serial and watchdog.
*/
// Design decisions made here: the register addresses and strobed register access.
`default_nettype none
`include "pm_clock_params.svh"

// Contract
// - writing idle bit enters idle once the writing instruction completes
// - idle stops the CPU clock, peripherals stay clocked, CPU state frozen
// - idle drives address latch and fetch strobe high, ports hold states
// - an enabled interrupt in idle clears idle bit and resumes execution
// - reset ending idle restarts at zero with reset values, no delay
// - watchdog runs in idle; reset follows 512 clocks after time-out
// - divide bits select 4, 64 or 1024 clocks per machine cycle
// - idle peripherals tick at clock/4; economy peripherals follow core rate
// - a new divide selection applies one instruction cycle after the write
// - source select picks crystal or RC after one instruction; status shows it
// - crystal select refused until crystal ready, set after warm-up
// - switchback on serial activity or taken external interrupt forces divide 4
// - receive start edge or buffer write triggers switchback, flags ignored
// - divide writes ignored while switchback enabled and serial busy
// - any reset forces divide 4
// - power-down bit stops all clocks after the writing instruction
// - power-down drives address latch and fetch strobe low
// - reset pin ends power-down; watchdog cannot
// - enabled low external interrupt with global enable ends power-down
// - RC-wake bit leaves power-down on RC, then moves to crystal when ready

module power_mode_clock_manager (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic instr_done,
  input wire logic int_wake,
  input wire logic rst_pin,
  input wire logic por_rst,
  input wire logic wdt_timeout,
  input wire logic wdt_clear,
  input wire logic wdt_rst_en,
  input wire logic [1:0] ext_int_n,
  input wire logic [1:0] ext_int_en,
  input wire logic global_int_enable,
  input wire logic ext_int_ack,
  input wire logic rx_pin,
  input wire logic rx_enable,
  input wire logic sbuf_write,
  input wire logic serial_busy,
  input wire logic crystal_stable,
  input wire logic ext_prog_mem,
  input wire logic ale_core,
  input wire logic fetch_strobe_core,
  output logic cpu_clk_run,
  output logic cpu_tick,
  output logic periph_tick,
  output logic osc_run,
  output logic crystal_amp_en,
  output logic rc_clk_sel,
  output logic core_rst,
  output logic ale_out,
  output logic prog_fetch_strobe_pin,
  output logic port0_float,
  output logic port2_addr_drive,
  output logic port_hold
);

  // ****************************************
  // helpers
  // ****************************************
  // last count of a machine cycle; reserved code falls back to divide 4
  function automatic logic [9:0] div_last(input logic [1:0] sel);
    case (sel)
      `PM_DIV_64: div_last = 10'h03F;
      `PM_DIV_1024: div_last = 10'h3FF;
      default: div_last = 10'h003;
    endcase
  endfunction

  pm_clock_pkg::pm_state_t state_q;
  logic idle_req_q, pd_req_q;
  logic [1:0] div_sel_q, div_act_q;
  logic swb_en_q, amp_off_q, src_sel_q, rc_wake_q, src_xt_q, rc_return_q;
  logic xt_ready_q;
  logic [4:0] s1_q, s2_q, s3_q, flt_q;
  logic rx_prev_q;
  logic [3:0] rst_cnt_q;
  logic rst_valid;
  logic wdt_arm_q, wdt_fire_q;
  logic [9:0] wdt_cnt_q;
  logic [9:0] mc_cnt_q, mc_last;
  logic mc_wrap, swb_fire, ext_wake, pmr_wr, div_locked;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // three stages; the filtered level moves only when stages two and three agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 5'h0E; // idle pin levels, so no false edge follows reset
      s2_q <= 5'h0E;
      s3_q <= 5'h0E;
      flt_q <= 5'h0E;
    end else begin
      s1_q <= {crystal_stable, ext_int_n, rx_pin, rst_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 5; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          flt_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ****************************************
  // reset sources
  // ****************************************
  // a glitch on the reset pin must not reset the core, so require 8 clocks
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_cnt_q <= 4'h0;
    end else if (!flt_q[0]) begin
      rst_cnt_q <= 4'h0;
    end else if (rst_cnt_q != 4'(`PM_RST_MIN_CLKS)) begin
      rst_cnt_q <= rst_cnt_q + 4'h1;
    end
  end
  assign rst_valid = flt_q[0] && (rst_cnt_q >= 4'(`PM_RST_MIN_CLKS - 1));

  // watchdog keeps counting in idle; its clock is gone in power-down
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_arm_q <= 1'b0;
      wdt_cnt_q <= 10'h000;
      wdt_fire_q <= 1'b0;
    end else begin
      wdt_fire_q <= 1'b0;
      if (wdt_clear || core_rst) begin
        wdt_arm_q <= 1'b0;
        wdt_cnt_q <= 10'h000;
      end else if (wdt_timeout && wdt_rst_en && !wdt_arm_q) begin
        wdt_arm_q <= 1'b1;
        wdt_cnt_q <= 10'h000;
      end else if (wdt_arm_q && state_q != pm_clock_pkg::ST_PDOWN) begin
        wdt_cnt_q <= wdt_cnt_q + 10'h001;
        if (wdt_cnt_q == 10'(`PM_WDT_RST_CLKS - 1)) begin
          wdt_fire_q <= 1'b1;
          wdt_arm_q <= 1'b0;
        end
      end
    end
  end

  // internal reset restarts the core at zero with no start-up delay
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_rst <= 1'b1;
    end else begin
      core_rst <= rst_valid || wdt_fire_q || por_rst;
    end
  end

  // ****************************************
  // mode state machine
  // ****************************************
  assign ext_wake = global_int_enable && |(~flt_q[3:2] & ext_int_en);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= pm_clock_pkg::ST_RUN;
      idle_req_q <= 1'b0;
      pd_req_q <= 1'b0;
    end else if (core_rst) begin
      state_q <= pm_clock_pkg::ST_RUN;
      idle_req_q <= 1'b0;
      pd_req_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `PM_ADDR_POWER_CONTROL_REG) begin
        idle_req_q <= reg_wdata[`PM_POWER_CONTROL_REG_IDLE];
        pd_req_q <= reg_wdata[`PM_POWER_CONTROL_REG_PDOWN];
      end
      case (state_q)
        pm_clock_pkg::ST_RUN: begin
          if (instr_done && pd_req_q) begin
            state_q <= pm_clock_pkg::ST_PDOWN;
          end else if (instr_done && idle_req_q) begin
            state_q <= pm_clock_pkg::ST_IDLE;
          end
        end
        pm_clock_pkg::ST_IDLE: begin
          if (int_wake) begin
            state_q <= pm_clock_pkg::ST_RUN;
            idle_req_q <= 1'b0;
          end
        end
        pm_clock_pkg::ST_PDOWN: begin
          if (ext_wake) begin
            state_q <= pm_clock_pkg::ST_RUN;
            pd_req_q <= 1'b0;
          end
        end
        default: state_q <= pm_clock_pkg::ST_RUN;
      endcase
    end
  end

  // ****************************************
  // economy divider and switchback
  // ****************************************
  // receive start edge, buffer write or a taken external interrupt
  assign swb_fire = swb_en_q && ((rx_enable && rx_prev_q && !flt_q[1])
                    || sbuf_write || ext_int_ack);
  assign pmr_wr = reg_wr && reg_addr == `PM_ADDR_PMR;
  assign div_locked = swb_en_q && serial_busy;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= flt_q[1];
    end
  end

  // a pending selection waits for the next instruction boundary
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_sel_q <= `PM_DIV_4;
      div_act_q <= `PM_DIV_4;
      swb_en_q <= 1'b0;
      amp_off_q <= 1'b0;
    end else if (core_rst) begin
      div_sel_q <= `PM_DIV_4;
      div_act_q <= `PM_DIV_4;
      swb_en_q <= 1'((`PM_PMR_RESET >> `PM_PMR_SWB) & 8'h01);
      amp_off_q <= 1'b0;
    end else begin
      if (pmr_wr) begin
        swb_en_q <= reg_wdata[`PM_PMR_SWB];
        amp_off_q <= reg_wdata[`PM_PMR_AMPOFF];
      end
      if (swb_fire) begin
        div_sel_q <= `PM_DIV_4;
        div_act_q <= `PM_DIV_4;
      end else begin
        if (pmr_wr && !div_locked) begin
          div_sel_q <= reg_wdata[`PM_PMR_DIV_LO +: 2];
        end
        if (instr_done) begin
          div_act_q <= div_sel_q;
        end
      end
    end
  end

  // idle peripherals always see clock/4 whatever the economy setting
  assign mc_last = (state_q == pm_clock_pkg::ST_IDLE) ? 10'h003 : div_last(div_act_q);
  assign mc_wrap = mc_cnt_q >= mc_last;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mc_cnt_q <= 10'h000;
    end else if (state_q != pm_clock_pkg::ST_PDOWN) begin
      mc_cnt_q <= mc_wrap ? 10'h000 : mc_cnt_q + 10'h001;
    end
  end

  // ****************************************
  // clock source and crystal warm-up
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      xt_ready_q <= 1'b0;
    end else begin
      xt_ready_q <= !amp_off_q && flt_q[4] && state_q != pm_clock_pkg::ST_PDOWN;
    end
  end

  // select bit written here; the active source follows one instruction later
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_sel_q <= 1'((`PM_EXT_INT_FLAG_REG_RESET >> `PM_EXT_INT_FLAG_REG_SRCSEL) & 8'h01);
      rc_wake_q <= 1'b0;
      src_xt_q <= 1'b0;
      rc_return_q <= 1'b0;
    end else if (core_rst) begin
      src_sel_q <= 1'b0;
      rc_wake_q <= 1'b0;
      src_xt_q <= 1'b0;
      rc_return_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `PM_ADDR_EXT_INT_FLAG_REG) begin
        src_sel_q <= reg_wdata[`PM_EXT_INT_FLAG_REG_SRCSEL] && xt_ready_q;
        rc_wake_q <= reg_wdata[`PM_EXT_INT_FLAG_REG_RCWAKE];
      end
      if (state_q == pm_clock_pkg::ST_PDOWN && ext_wake && rc_wake_q) begin
        src_xt_q <= 1'b0;
        rc_return_q <= 1'b1;
      end else if (rc_return_q) begin
        if (xt_ready_q) begin
          src_xt_q <= 1'b1;
          rc_return_q <= 1'b0;
        end
      end else if (instr_done) begin
        src_xt_q <= src_sel_q && xt_ready_q;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // gates and pin overrides follow the registered mode one cycle later
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk_run <= 1'b1;
      cpu_tick <= 1'b0;
      periph_tick <= 1'b0;
      osc_run <= 1'b1;
      crystal_amp_en <= 1'b1;
      rc_clk_sel <= 1'b1;
      ale_out <= 1'b0;
      prog_fetch_strobe_pin <= 1'b1;
      port0_float <= 1'b0;
      port2_addr_drive <= 1'b0;
      port_hold <= 1'b0;
    end else begin
      cpu_clk_run <= state_q == pm_clock_pkg::ST_RUN;
      cpu_tick <= mc_wrap && state_q == pm_clock_pkg::ST_RUN;
      periph_tick <= mc_wrap && state_q != pm_clock_pkg::ST_PDOWN;
      osc_run <= state_q != pm_clock_pkg::ST_PDOWN;
      crystal_amp_en <= !amp_off_q;
      rc_clk_sel <= !src_xt_q;
      case (state_q)
        pm_clock_pkg::ST_IDLE: begin
          ale_out <= 1'b1;
          prog_fetch_strobe_pin <= 1'b1;
          port0_float <= ext_prog_mem;
          port2_addr_drive <= ext_prog_mem;
          port_hold <= 1'b1;
        end
        pm_clock_pkg::ST_PDOWN: begin
          ale_out <= 1'b0;
          prog_fetch_strobe_pin <= 1'b0;
          port0_float <= ext_prog_mem;
          port2_addr_drive <= 1'b0;
          port_hold <= 1'b0;
        end
        default: begin
          ale_out <= ale_core;
          prog_fetch_strobe_pin <= fetch_strobe_core;
          port0_float <= 1'b0;
          port2_addr_drive <= 1'b0;
          port_hold <= 1'b0;
        end
      endcase
    end
  end

  // register read data, valid in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PM_ADDR_POWER_CONTROL_REG: reg_rdata <= {6'h00, pd_req_q, idle_req_q};
        `PM_ADDR_PMR: reg_rdata <= {div_sel_q, swb_en_q, 1'b0, amp_off_q, 3'h0};
        `PM_ADDR_EXT_INT_FLAG_REG: reg_rdata <= {4'h0, src_sel_q, !src_xt_q, rc_wake_q, 1'b0};
        default: reg_rdata <= {3'h0, xt_ready_q, 4'h0};
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence idle_go;
    state_q == pm_clock_pkg::ST_RUN && idle_req_q && !pd_req_q && instr_done && !core_rst;
  endsequence
  sequence idle_hold4;
    (state_q == pm_clock_pkg::ST_IDLE && !core_rst)[*4];
  endsequence

  AST_IDLE_ENTER: assert property (idle_go |=> state_q == pm_clock_pkg::ST_IDLE ##1 !cpu_clk_run)
    else $error("idle not entered after request");
  AST_IDLE_TICK: assert property ((periph_tick && state_q == pm_clock_pkg::ST_IDLE) ##1 idle_hold4
    |-> periph_tick)
    else $error("idle peripheral tick not every 4 clocks");
  AST_IDLE_WAKE: assert property ((state_q == pm_clock_pkg::ST_IDLE && int_wake && !core_rst)
    |=> state_q == pm_clock_pkg::ST_RUN && !idle_req_q)
    else $error("interrupt did not end idle");
  AST_RST_RUN: assert property (core_rst |=> state_q == pm_clock_pkg::ST_RUN && !pd_req_q)
    else $error("reset did not return to run");
  AST_WDT_RST: assert property (wdt_fire_q |=> core_rst)
    else $error("watchdog time-out did not reset");
  AST_DIV_DELAY: assert property ((div_act_q != $past(div_act_q)) |->
    $past(instr_done) || $past(swb_fire) || $past(core_rst))
    else $error("divide changed off an instruction boundary");
  AST_SWB: assert property (swb_fire && !core_rst |=> div_act_q == `PM_DIV_4
    && div_sel_q == `PM_DIV_4)
    else $error("switchback did not force divide 4");
  AST_XT_REFUSE: assert property ((reg_wr && reg_addr == `PM_ADDR_EXT_INT_FLAG_REG && !xt_ready_q && !core_rst)
    |=> !src_sel_q)
    else $error("crystal select accepted before ready");
  AST_PD_PINS: assert property ((state_q == pm_clock_pkg::ST_PDOWN)[*2]
    |-> !ale_out && !prog_fetch_strobe_pin && !osc_run)
    else $error("power-down pins not low");
  AST_PD_PRIO: assert property ((state_q == pm_clock_pkg::ST_RUN && pd_req_q && idle_req_q
    && instr_done && !core_rst) |=> state_q == pm_clock_pkg::ST_PDOWN)
    else $error("idle won over power-down");

endmodule

`default_nettype wire

// [tb/test_power_mode_clock_manager.sv]
/*
  Self-checking bench of the power-mode and clock manager: idle, power-down,
  divide selection, switchback, clock source and reset exits.
  Assumes the register map header and one free-running 125 MHz clock.
*/
`default_nettype none
`include "pm_clock_params.svh"

module test_power_mode_clock_manager;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, instr_done = 1'b0, int_wake = 1'b0;
  logic rst_pin = 1'b0, por_rst = 1'b0, wdt_timeout = 1'b0, wdt_clear = 1'b0;
  logic wdt_rst_en = 1'b0, global_int_enable = 1'b0, ext_int_ack = 1'b0;
  logic [1:0] ext_int_n = 2'h3;
  logic [1:0] ext_int_en = 2'h0;
  logic rx_pin = 1'b1, rx_enable = 1'b1, sbuf_write = 1'b0, serial_busy = 1'b0;
  logic crystal_stable = 1'b0, ext_prog_mem = 1'b0;
  logic ale_core = 1'b0, fetch_strobe_core = 1'b1;
  logic cpu_clk_run, cpu_tick, periph_tick, osc_run, crystal_amp_en, rc_clk_sel;
  logic core_rst, ale_out, prog_fetch_strobe_pin, port0_float, port2_addr_drive;
  logic port_hold;
  int mismatches = 0, compares = 0, cycles = 0;

  power_mode_clock_manager i_power_mode_clock_manager (
    .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .instr_done, .int_wake, .rst_pin, .por_rst, .wdt_timeout, .wdt_clear,
    .wdt_rst_en, .ext_int_n, .ext_int_en, .global_int_enable, .ext_int_ack,
    .rx_pin, .rx_enable, .sbuf_write, .serial_busy, .crystal_stable,
    .ext_prog_mem, .ale_core, .fetch_strobe_core, .cpu_clk_run, .cpu_tick,
    .periph_tick, .osc_run, .crystal_amp_en, .rc_clk_sel, .core_rst, .ale_out,
    .prog_fetch_strobe_pin, .port0_float, .port2_addr_drive, .port_hold
  );

  always #4 ref_clk = ~ref_clk;

  // hang guard: the whole run needs far fewer cycles than this
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic step_instr;
    @(posedge ref_clk);
    instr_done <= 1'b1;
    @(posedge ref_clk);
    instr_done <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // cycles between two ticks; called twice so a rate change mid-period is skipped
  task automatic per(input logic use_p, output int n);
    int w;
    w = 0;
    n = 0;
    while ((use_p ? periph_tick : cpu_tick) !== 1'b1 && w < 2100) begin
      waitc(1);
      w++;
    end
    do begin
      waitc(1);
      n++;
    end while ((use_p ? periph_tick : cpu_tick) !== 1'b1 && n < 2100);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_vals;
    rd(`PM_ADDR_POWER_CONTROL_REG, 8'h00);
    rd(`PM_ADDR_PMR, 8'h40);
    rd(`PM_ADDR_STATUS, 8'h00);
    $display("test reset_vals done");
  endtask

  task automatic t_source;
    wr(`PM_ADDR_EXT_INT_FLAG_REG, 8'h08);
    step_instr;
    waitc(3);
    chk(rc_clk_sel, 1'b1);
    wr(`PM_ADDR_PMR, 8'h48);
    waitc(2);
    chk(crystal_amp_en, 1'b0);
    wr(`PM_ADDR_PMR, 8'h40);
    crystal_stable <= 1'b1;
    waitc(8);
    chk(crystal_amp_en, 1'b1);
    rd(`PM_ADDR_STATUS, 8'h10);
    wr(`PM_ADDR_EXT_INT_FLAG_REG, 8'h08);
    step_instr;
    waitc(3);
    chk(rc_clk_sel, 1'b0);
    $display("test source done");
  endtask

  task automatic t_idle;
    int n;
    ext_prog_mem <= 1'b1;
    wr(`PM_ADDR_POWER_CONTROL_REG, 8'h01);
    step_instr;
    waitc(3);
    chk(cpu_clk_run, 1'b0);
    chk({ale_out, prog_fetch_strobe_pin, port_hold}, 3'h7);
    chk({port0_float, port2_addr_drive}, 2'h3);
    per(1'b1, n);
    per(1'b1, n);
    chk(n, 4);
    int_wake <= 1'b1;
    waitc(3);
    int_wake <= 1'b0;
    chk(cpu_clk_run, 1'b1);
    rd(`PM_ADDR_POWER_CONTROL_REG, 8'h00);
    $display("test idle done");
  endtask

  task automatic t_pdown;
    ext_int_en <= 2'h1;
    global_int_enable <= 1'b1;
    wr(`PM_ADDR_EXT_INT_FLAG_REG, 8'h0A);
    wr(`PM_ADDR_POWER_CONTROL_REG, 8'h03);
    step_instr;
    waitc(3);
    crystal_stable <= 1'b0;
    chk({osc_run, cpu_clk_run}, 2'h0);
    chk({ale_out, prog_fetch_strobe_pin, port0_float, port2_addr_drive}, 4'h2);
    int_wake <= 1'b1;
    waitc(6);
    int_wake <= 1'b0;
    chk(osc_run, 1'b0);
    ext_int_n <= 2'h2;
    waitc(8);
    ext_int_n <= 2'h3;
    chk({osc_run, cpu_clk_run, rc_clk_sel}, 3'h7);
    crystal_stable <= 1'b1;
    waitc(10);
    chk(rc_clk_sel, 1'b0);
    wr(`PM_ADDR_POWER_CONTROL_REG, 8'h00);
    $display("test pdown done");
  endtask

  task automatic t_divide;
    int n;
    for (int k = 0; k < 3; k++) begin
      wr(`PM_ADDR_PMR, 8'hA0);
      per(1'b0, n);
      chk(n, 4);
      step_instr;
      per(1'b0, n);
      per(1'b0, n);
      chk(n, 64);
      @(posedge ref_clk);
      case (k)
        0: sbuf_write <= 1'b1;
        1: ext_int_ack <= 1'b1;
        default: rx_pin <= 1'b0;
      endcase
      @(posedge ref_clk);
      sbuf_write <= 1'b0;
      ext_int_ack <= 1'b0;
      waitc(5);
      rx_pin <= 1'b1;
      per(1'b0, n);
      per(1'b0, n);
      chk(n, 4);
    end
    serial_busy <= 1'b1;
    wr(`PM_ADDR_PMR, 8'hA0);
    step_instr;
    per(1'b0, n);
    per(1'b0, n);
    chk(n, 4);
    serial_busy <= 1'b0;
    wr(`PM_ADDR_PMR, 8'hC0);
    step_instr;
    per(1'b0, n);
    per(1'b0, n);
    chk(n, 1024);
    wr(`PM_ADDR_PMR, 8'h40);
    step_instr;
    wr(`PM_ADDR_PMR, 8'h00);
    step_instr;
    per(1'b0, n);
    per(1'b0, n);
    chk(n, 4);
    rd(`PM_ADDR_PMR, 8'h00);
    $display("test divide done");
  endtask

  task automatic t_rstpin;
    int n;
    wr(`PM_ADDR_PMR, 8'h80);
    wr(`PM_ADDR_POWER_CONTROL_REG, 8'h01);
    step_instr;
    rst_pin <= 1'b1;
    waitc(5);
    rst_pin <= 1'b0;
    waitc(8);
    chk({core_rst, cpu_clk_run}, 2'h0);
    rst_pin <= 1'b1;
    waitc(14);
    chk(core_rst, 1'b1);
    rst_pin <= 1'b0;
    waitc(10);
    chk({core_rst, cpu_clk_run}, 2'h1);
    rd(`PM_ADDR_POWER_CONTROL_REG, 8'h00);
    rd(`PM_ADDR_PMR, 8'h40);
    per(1'b0, n);
    chk(n, 4);
    $display("test rstpin done");
  endtask

  task automatic t_wdog;
    int n;
    wdt_rst_en <= 1'b1;
    wr(`PM_ADDR_POWER_CONTROL_REG, 8'h01);
    step_instr;
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      wdt_timeout <= 1'b1;
      @(posedge ref_clk);
      wdt_timeout <= 1'b0;
      if (k == 0) begin
        waitc(100);
        wdt_clear <= 1'b1;
        waitc(1);
        wdt_clear <= 1'b0;
        waitc(600);
      end else begin
        waitc(505);
      end
      chk(core_rst, 1'b0);
    end
    n = 0;
    while (core_rst !== 1'b1 && n < 20) begin
      waitc(1);
      n++;
    end
    chk(core_rst, 1'b1);
    wdt_rst_en <= 1'b0;
    waitc(12);
    chk(cpu_clk_run, 1'b1);
    $display("test wdog done");
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // reset for two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    waitc(3);
    t_reset_vals;
    t_source;
    t_idle;
    t_pdown;
    t_divide;
    t_rstpin;
    t_wdog;
    stop_test();
  end
endmodule

`default_nettype wire
